// File: rtl/rtamp_defines.vh
// Constants for the tamper input control block
// =====================================================================
// Notes on behaviour
// - Per-input debounce enable; clear samples raw, set debounces before edge detection.
// - Per-input polarity bit: 0 detects falling edge, 1 detects rising edge.
// - Two-bit action per channel packed from bit 0 upward; code 0 means off.
// - Action 1 on selected edge wakes the system and sets the tamper flag.
// - Action 2 on selected edge captures counter timestamp and sets tamper flag.
// - Action 3 drives counter signal out, compares input; mismatch captures and flags.
// - With event output enabled, one event pulse per cycle in which any tamper is detected; none otherwise.
// =====================================================================
`ifndef RTAMP_DEFINES_VH
`define RTAMP_DEFINES_VH

// Register byte offsets
`define RTAMP_OFF_CTRL 8'h00
`define RTAMP_OFF_EVCTRL 8'h04
`define RTAMP_OFF_TAMPER_CONTROL 8'h60
`define RTAMP_OFF_STATUS 8'h64
`define RTAMP_OFF_MASK 8'h68
`define RTAMP_OFF_TSTAMP 8'h6C
`define RTAMP_OFF_TAMPID 8'h70

// Field positions
`define RTAMP_ACT_LSB 0
`define RTAMP_POL_LSB 16
`define RTAMP_DEB_LSB 24
`define RTAMP_CTRL_ENABLE 0
`define RTAMP_CTRL_WPROT 1
`define RTAMP_EV_TAMPEO 14
`define RTAMP_ST_TAMPER 0
`define RTAMP_ST_WAKE 1

// Reset values
`define RTAMP_RST_TAMPER_CONTROL 32'h00000000
`define RTAMP_TAMPER_CONTROL_MASK 32'h1F1F03FF

// Action codes
`define RTAMP_ACT_OFF 2'h0
`define RTAMP_ACT_WAKE 2'h1
`define RTAMP_ACT_CAPTURE 2'h2
`define RTAMP_ACT_LOOP 2'h3

// Debounce hold: 100 ns at the 10 ns clock, sized to the filter's 4-bit count
`define RTAMP_DEB_CYCLES 4'hA

`endif

// File: rtl/rtamp_debounce.v
// Per-input debounce filter with bypass
`timescale 1ns/10ps
module rtamp_debounce #(
    parameter CNT_W = 4,
    parameter [3:0] CYCLES = 4'hA
) (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Control
    input wire enable,
    // Signal
    input wire din,
    output wire dout
);
    reg stable_r;
    reg [CNT_W-1:0] cnt_r;

    // =================================================================
    // Filter: input must hold a new level CYCLES cycles before it is taken
    always @(posedge aclk) begin
        if (!aresetn) begin
            stable_r <= 1'b0;
            cnt_r <= {CNT_W{1'b0}};
        end else if (din == stable_r) begin
            cnt_r <= {CNT_W{1'b0}};
        end else if (cnt_r >= CYCLES - 4'h1) begin
            stable_r <= din;
            cnt_r <= {CNT_W{1'b0}};
        end else begin
            cnt_r <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    // Bypass keeps the raw path when debouncing is off
    assign dout = enable ? stable_r : din;
endmodule // rtamp_debounce

// File: rtl/rtamp_top.v
// Tamper input control block with AXI4-Lite register slave
`timescale 1ns/10ps
`include "rtamp_defines.vh"
module rtamp_top #(
    parameter NCH = 5,
    parameter CW = 32
) (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // AXI4-Lite write address
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // AXI4-Lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // AXI4-Lite write response
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // AXI4-Lite read data
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    // Counter value
    input wire [CW-1:0] counter_value,
    input wire counter_pattern,
    // Tamper pins
    input wire [NCH-1:0] tamper_input_pin,
    output wire [NCH-1:0] tamper_output_pin,
    // Events and interrupt
    output wire wake_out,
    output wire tamper_event_out,
    output wire irq
);
    // =================================================================
    // Registers
    reg [31:0] ctrl_r;
    reg [31:0] evctrl_r;
    reg [31:0] tamper_control_r;
    reg [1:0] status_r;
    reg [1:0] mask_r;
    reg [CW-1:0] tstamp_r;
    reg [NCH-1:0] tampid_r;
    reg [NCH-1:0] prev_r;
    reg [NCH-1:0] outpin_r;
    reg [NCH-1:0] cmp_r;
    reg wake_r;
    reg event_r;
    reg [7:0] awaddr_r;
    reg aw_have_r;
    reg [31:0] wdata_r;
    reg [3:0] wstrb_r;
    reg w_have_r;
    reg bvalid_r;
    reg [1:0] bresp_r;
    reg rvalid_r;
    reg [31:0] rdata_r;
    reg [1:0] rresp_r;

    wire [NCH-1:0] filt;
    wire [NCH-1:0] hit;
    reg [31:0] rd_nxt;
    reg rd_ok;
    integer i;

    // =================================================================
    // Overview
    // Five tamper channels share one control word. Per channel n:
    //   bits 2n+1:2n  action (off, wake, capture, loop compare)
    //   bit 16+n      edge polarity, 1 selects the rising edge
    //   bit 24+n      debounce enable
    // Unused control bits read back as zero and ignore writes.
    //
    // Register map, byte offsets on the 8-bit bus address:
    //   0x00  control: bit 0 counter enable, bit 1 write protect
    //   0x04  event control: bit 14 enables the tamper event pulse
    //   0x60  tamper control, writable only while unlocked
    //   0x64  status: bit 0 tamper, bit 1 wake, write one to clear
    //   0x68  interrupt mask, same layout as status
    //   0x6C  timestamp, read only
    //   0x70  sticky record of channels that fired, read only
    // Any other offset answers with a slave error; reads return zero.
    //
    // Detection timing, counted from the edge that shows a new level:
    //   raw path: hit in the same cycle, flags one edge later
    //   debounced path: the level must hold ten cycles first
    //   the wake flag lags the tamper flag by one cycle, since it
    //   is set from the registered wake pulse
    // A short glitch restarts the debounce count, so it never
    // reaches the edge detector.
    //
    // Loop compare: the output pin is registered and the returned
    // input is expected one cycle later, so the comparison uses the
    // value driven on the previous cycle. A loop with any other
    // latency reads as a mismatch on every pattern change.
    // Debouncing must stay off on a loop channel: the filter would
    // delay the return and every change would look like a cut.
    // A mismatch fires on every cycle it lasts, so the timestamp
    // holds the counter value of the last mismatching cycle.
    //
    // Several channels firing together give one event pulse and one
    // timestamp, taken from the counter value of that cycle.
    //
    // Status bits are set by hardware and cleared by software; when
    // both meet on one edge the set is kept, so no event is lost.
    //
    // Bus timing: a write response rises on the edge after both
    // halves are held; a read answers one cycle after its address.
    // Only one write and one read are held at a time; the ready
    // signals stay low while a response waits to be accepted.
    // Locked tamper control writes still get an okay response, so
    // software must read back to learn whether a write landed.
    //
    // Trade-off: the filters run even while bypassed, so turning
    // debounce on never shows a stale level to the edge detector.

    // =================================================================
    // Per-channel debounce and detection
    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : g_ch
            wire [1:0] act = tamper_control_r[`RTAMP_ACT_LSB + 2*g +: 2];
            wire pol = tamper_control_r[`RTAMP_POL_LSB + g];
            wire deb = tamper_control_r[`RTAMP_DEB_LSB + g];
            wire rise = filt[g] & ~prev_r[g];
            wire fall = ~filt[g] & prev_r[g];
            rtamp_debounce #(
                .CNT_W(4),
                .CYCLES(`RTAMP_DEB_CYCLES)
            ) u_deb (
                .aclk(aclk),
                .aresetn(aresetn),
                .enable(deb),
                .din(tamper_input_pin[g]),
                .dout(filt[g])
            );
            // Edge channels fire on the selected edge, compare channels on mismatch
            assign hit[g] = (act == `RTAMP_ACT_OFF) ? 1'b0 :
                            (act == `RTAMP_ACT_LOOP) ? (filt[g] != cmp_r[g]) :
                            (pol ? rise : fall);
        end
    endgenerate

    // Output pin carries the counter pattern on compare channels only
    assign tamper_output_pin = outpin_r;

    // =================================================================
    // Detection state, timestamp, events
    always @(posedge aclk) begin
        if (!aresetn) begin
            prev_r <= {NCH{1'b0}};
            outpin_r <= {NCH{1'b0}};
            cmp_r <= {NCH{1'b0}};
            tstamp_r <= {CW{1'b0}};
            tampid_r <= {NCH{1'b0}};
            wake_r <= 1'b0;
            event_r <= 1'b0;
        end else begin
            prev_r <= filt;
            wake_r <= 1'b0;
            for (i = 0; i < NCH; i = i + 1) begin
                // Compare against what was driven a cycle earlier: the loop has latency
                cmp_r[i] <= outpin_r[i];
                outpin_r[i] <= (tamper_control_r[2*i +: 2] == `RTAMP_ACT_LOOP) ? counter_pattern : 1'b0;
                if (hit[i] && tamper_control_r[2*i +: 2] == `RTAMP_ACT_WAKE) begin
                    wake_r <= 1'b1;
                end
            end
            event_r <= (|hit) & evctrl_r[`RTAMP_EV_TAMPEO];
            if (|hit) begin
                tampid_r <= tampid_r | hit;
            end
            // Capture only for capture or compare channels
            for (i = 0; i < NCH; i = i + 1) begin
                if (hit[i] && tamper_control_r[2*i+1]) begin
                    tstamp_r <= counter_value;
                end
            end
        end
    end

    assign wake_out = wake_r;
    assign tamper_event_out = event_r;
    assign irq = |(status_r & mask_r);

    // =================================================================
    // AXI4-Lite write path; address and data may come in either order
    assign s_axi_awready = ~aw_have_r & ~bvalid_r;
    assign s_axi_wready = ~w_have_r & ~bvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;

    wire do_write = aw_have_r & w_have_r & ~bvalid_r;
    wire ctrl_locked = ctrl_r[`RTAMP_CTRL_ENABLE] | ctrl_r[`RTAMP_CTRL_WPROT];
    wire [31:0] wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};

    always @(posedge aclk) begin
        if (!aresetn) begin
            awaddr_r <= 8'h00;
            aw_have_r <= 1'b0;
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
            w_have_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= 2'h0;
            ctrl_r <= 32'h00000000;
            evctrl_r <= 32'h00000000;
            tamper_control_r <= `RTAMP_RST_TAMPER_CONTROL;
            status_r <= 2'h0;
            mask_r <= 2'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awaddr_r <= s_axi_awaddr;
                aw_have_r <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
                w_have_r <= 1'b1;
            end
            if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
            // Status: write-one-to-clear, hardware set wins over the clear
            if (do_write && awaddr_r == `RTAMP_OFF_STATUS) begin
                status_r <= status_r & ~(wdata_r[1:0] & wmask[1:0]);
            end
            if (|hit) begin
                status_r[`RTAMP_ST_TAMPER] <= 1'b1;
            end
            if (wake_r) begin
                status_r[`RTAMP_ST_WAKE] <= 1'b1;
            end
            if (do_write) begin
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= 2'h0;
                case (awaddr_r)
                    `RTAMP_OFF_CTRL: ctrl_r <= ((ctrl_r & ~wmask) | (wdata_r & wmask)) & 32'h00000003;
                    `RTAMP_OFF_EVCTRL: evctrl_r <= ((evctrl_r & ~wmask) | (wdata_r & wmask)) & 32'h00004000;
                    `RTAMP_OFF_TAMPER_CONTROL: begin
                        // Locked writes complete but leave the register unchanged
                        if (!ctrl_locked) begin
                            tamper_control_r <= ((tamper_control_r & ~wmask) | (wdata_r & wmask))
                                                & `RTAMP_TAMPER_CONTROL_MASK;
                        end
                    end
                    `RTAMP_OFF_STATUS: bresp_r <= 2'h0;
                    `RTAMP_OFF_MASK: mask_r <= (mask_r & ~wmask[1:0]) | (wdata_r[1:0] & wmask[1:0]);
                    `RTAMP_OFF_TSTAMP: bresp_r <= 2'h0;
                    `RTAMP_OFF_TAMPID: bresp_r <= 2'h0;
                    default: bresp_r <= 2'h2;
                endcase
            end
        end
    end

    // =================================================================
    // AXI4-Lite read path; one outstanding read, answer one cycle after address
    assign s_axi_arready = ~rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    // Read mux
    always @* begin
        rd_nxt = 32'h00000000;
        rd_ok = 1'b1;
        case (s_axi_araddr)
            `RTAMP_OFF_CTRL: rd_nxt = ctrl_r;
            `RTAMP_OFF_EVCTRL: rd_nxt = evctrl_r;
            `RTAMP_OFF_TAMPER_CONTROL: rd_nxt = tamper_control_r;
            `RTAMP_OFF_STATUS: rd_nxt = {30'h00000000, status_r};
            `RTAMP_OFF_MASK: rd_nxt = {30'h00000000, mask_r};
            `RTAMP_OFF_TSTAMP: rd_nxt = tstamp_r;
            `RTAMP_OFF_TAMPID: rd_nxt = {{(32-NCH){1'b0}}, tampid_r};
            default: rd_ok = 1'b0;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h00000000;
            rresp_r <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_nxt;
            rresp_r <= rd_ok ? 2'h0 : 2'h2;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end
endmodule // rtamp_top

// File: tb/rtamp_chk.sv
// Port checker for the tamper input control block
`timescale 1ns/10ps
module rtamp_chk #(
    parameter NCH = 5
) (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Register bus
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    // Tamper side
    input wire counter_pattern,
    input wire [NCH-1:0] tamper_output_pin,
    input wire wake_out,
    input wire tamper_event_out,
    input wire irq
);
    // =====================================================================
    // Properties, all in the one clock domain
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_write_answered: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:3] s_axi_bvalid) else $error("write response missing");
    a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_read_answered: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_error_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
        else $error("error read carries data");
    a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    a_pattern_out: assert property (!$past(counter_pattern) |-> tamper_output_pin == '0)
        else $error("loop pin driven without pattern");
    a_quiet_reset: assert property (!$past(aresetn) |-> !wake_out && !tamper_event_out && !irq)
        else $error("outputs active after reset");
    // Main scenarios reached
    c_event: cover property (tamper_event_out);
    c_wake: cover property (wake_out);
    c_irq: cover property ($fell(irq));
endmodule // rtamp_chk
bind rtamp_top rtamp_chk #(.NCH(NCH)) u_chk (.*);

// File: tb/rtamp_switch.sv
// Model of the tamper switches and active-layer loop wiring
`timescale 1ns/10ps
module rtamp_switch (
    // Clock of the loop return path
    input wire aclk,
    // Loop wiring from the block
    input wire [4:0] tamper_output_pin,
    // Scenario commands
    input wire [4:0] level,
    input wire [4:0] loop_sel,
    input wire loop_break,
    // Back to the block
    output wire [4:0] tamper_input_pin
);
    reg [4:0] loop_q = 5'h00;
    // The loop returns one clock after the pin leaves the block
    always @(posedge aclk) begin
        loop_q <= tamper_output_pin;
    end
    // A cut loop reads inverted, so every pattern bit mismatches
    assign tamper_input_pin = (loop_sel & (loop_q ^ {5{loop_break}})) | (~loop_sel & level);
endmodule // rtamp_switch

// File: tb/test_rtc_tamper_input_control.sv
// Self-checking bench for the tamper input control block
`timescale 1ns/10ps
`include "rtamp_defines.vh"
module test_rtc_tamper_input_control;
    // =====================================================================
    // Signals
    logic aclk = 0, aresetn = 0, counter_pattern = 0, loop_break = 0, pat_q = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, counter_value = 0, g_data;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [4:0] level = 0, loop_sel = 0;
    logic [1:0] g_resp, s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [4:0] tamper_input_pin, tamper_output_pin;
    logic wake_out, tamper_event_out, irq;
    integer err_total = 0, checks_done = 0, ev_cnt = 0, wk_cnt = 0;
    rtamp_top DUT (.*);
    rtamp_switch u_sw (.*);
    initial forever #5 aclk = ~aclk;
    // Pulse counters and a free-running loop pattern
    always @(posedge aclk) begin
        ev_cnt <= ev_cnt + tamper_event_out;
        wk_cnt <= wk_cnt + wake_out;
        counter_pattern <= 1'($urandom);
        pat_q <= counter_pattern;
    end
    // =====================================================================
    // Tasks
    task report_and_stop;
        if (err_total == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string nm, input [31:0] exp, input [31:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
            err_total++;
        end
    endtask
    // One bus access; each channel released at the edge that takes it
    task automatic xfer(input bit wr, input [7:0] a, input [31:0] d);
        logic ta, tw, tr, done;
        done = 0;
        if (wr) begin
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'h1;
            s_axi_wvalid <= 1'h1;
            s_axi_bready <= 1'h1;
        end else begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'h1;
            s_axi_rready <= 1'h1;
        end
        for (int i = 0; i < 40 && !done; i++) begin
            @(negedge aclk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tr = s_axi_arvalid && s_axi_arready;
            done = wr ? s_axi_bvalid : s_axi_rvalid;
            g_resp = wr ? s_axi_bresp : s_axi_rresp;
            g_data = s_axi_rdata;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'h0;
            if (tw) s_axi_wvalid <= 1'h0;
            if (tr) s_axi_arvalid <= 1'h0;
            if (done) s_axi_bready <= 1'h0;
            if (done) s_axi_rready <= 1'h0;
        end
        if (!done) begin
            err_total++;
            report_and_stop;
        end
        @(posedge aclk);
    endtask
    task automatic rdc(input string nm, input [7:0] a, input [31:0] exp);
        xfer(0, a, 0);
        chk(nm, exp, g_data);
    endtask
    task automatic irq_chk(input [31:0] exp);
        @(negedge aclk);
        chk("irq", exp, irq);
        @(posedge aclk);
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge aclk);
    endtask
    // =====================================================================
    // Main sequence
    initial begin
        int ch, act, pol, deb, en, m, e0, w0;
        logic [31:0] ts, ids;
        void'($urandom(32'h5401dadf));
        ids = 0;
        wait_n(12);
        aresetn <= 1'h1;
        wait_n(1);
        rdc("ctrl reset", `RTAMP_OFF_TAMPER_CONTROL, `RTAMP_RST_TAMPER_CONTROL);
        xfer(0, 8'h80, 0);
        chk("unmapped resp", 2, g_resp);
        for (m = 1; m < 3; m++) begin
            xfer(1, `RTAMP_OFF_CTRL, m);
            xfer(1, `RTAMP_OFF_TAMPER_CONTROL, 32'hFFFFFFFF);
            xfer(1, `RTAMP_OFF_CTRL, 0);
            rdc("locked ctrl", `RTAMP_OFF_TAMPER_CONTROL, 0);
        end
        ts = $urandom;
        xfer(1, `RTAMP_OFF_TAMPER_CONTROL, ts);
        rdc("ctrl", `RTAMP_OFF_TAMPER_CONTROL, ts & `RTAMP_TAMPER_CONTROL_MASK);
        // Loop channels of this word compare against an idle pin and fire
        wait_n(30);
        for (ch = 0; ch < 5; ch++) ids[ch] = (ts[2 * ch +: 2] == 2'h3);
        rdc("loop ids", `RTAMP_OFF_TAMPID, ids);
        // Wrong edge, a short glitch on debounced runs, then the selected edge on each channel
        for (ch = 0; ch < 5; ch++) for (act = 0; act < 3; act++) begin
            pol = $urandom_range(1, 0);
            deb = $urandom_range(1, 0);
            en = $urandom_range(1, 0);
            m = $urandom_range(3, 0);
            xfer(1, `RTAMP_OFF_TAMPER_CONTROL, 0);
            level <= {5{pol[0]}};
            wait_n(15);
            xfer(1, `RTAMP_OFF_TAMPER_CONTROL, (act << 2 * ch) | (pol << 16 + ch) | (deb << 24 + ch));
            xfer(1, `RTAMP_OFF_EVCTRL, en << 14);
            xfer(1, `RTAMP_OFF_MASK, m);
            xfer(1, `RTAMP_OFF_STATUS, 3);
            e0 = ev_cnt;
            w0 = wk_cnt;
            level[ch] <= !pol;
            wait_n(15);
            if (deb) begin
                level[ch] <= pol;
                wait_n(3);
                level[ch] <= !pol;
                wait_n(15);
            end
            rdc("status quiet", `RTAMP_OFF_STATUS, 0);
            ts = $urandom;
            counter_value <= ts;
            level[ch] <= pol;
            wait_n(15);
            counter_value <= ~ts;
            rdc("status", `RTAMP_OFF_STATUS, {act == 1, act != 0});
            irq_chk(({act == 1, act != 0} & m) != 0);
            chk("wakes", act == 1, wk_cnt - w0);
            chk("events", en && act != 0, ev_cnt - e0);
            if (act == 2) rdc("stamp", `RTAMP_OFF_TSTAMP, ts);
            if (act != 0) ids[ch] = 1'h1;
            rdc("hit ids", `RTAMP_OFF_TAMPID, ids);
            xfer(1, `RTAMP_OFF_STATUS, 3);
            irq_chk(0);
        end
        // Active layer: intact loop stays quiet, a cut loop is caught
        ch = $urandom_range(4, 0);
        xfer(1, `RTAMP_OFF_TAMPER_CONTROL, 0);
        loop_sel <= 5'h01 << ch;
        xfer(1, `RTAMP_OFF_TAMPER_CONTROL, 3 << 2 * ch);
        xfer(1, `RTAMP_OFF_STATUS, 3);
        wait_n(30);
        rdc("loop intact", `RTAMP_OFF_STATUS, 0);
        // Only the loop channel drives, with the pattern of the cycle before
        @(negedge aclk);
        chk("loop pin", {4'h0, pat_q} << ch, tamper_output_pin);
        @(posedge aclk);
        ts = $urandom;
        counter_value <= ts;
        loop_break <= 1'h1;
        wait_n(5);
        loop_break <= 1'h0;
        rdc("loop cut", `RTAMP_OFF_STATUS, 1);
        rdc("loop stamp", `RTAMP_OFF_TSTAMP, ts);
        report_and_stop;
    end
endmodule // test_rtc_tamper_input_control
